// ### hdl/mad_pkg.sv
package mad_pkg;
   localparam int OP_W       = 12;
   localparam int C_W        = 24;
   localparam int FULL_W     = 26;
   localparam int DATA_W     = 32;
   localparam int STAGES     = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W      = 5;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_OPA    = 8'h04;
   localparam logic [7:0] ADDR_OPB    = 8'h08;
   localparam logic [7:0] ADDR_OPC    = 8'h0c;
   localparam logic [7:0] ADDR_ISSUE  = 8'h10;
   localparam logic [7:0] ADDR_RESULT = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_FMT    = 8'h1c;
   localparam logic [7:0] ADDR_NONE   = 8'hff;
   localparam logic [2:0] HSIZE_WORD  = 3'h2;

   localparam int CTRL_LAT_LSB = 0;
   localparam int CTRL_FP      = 3;
   localparam int CTRL_USEEN   = 4;
   localparam int CTRL_OP_LSB  = 5;
   localparam int CTRL_USER    = 8;
   localparam int CTRL_OSGN    = 9;
   localparam int CTRL_ISGN    = 10;
   localparam int CTRL_RND     = 11;
   localparam int CTRL_SAT     = 12;
   localparam int FMT_NB_LSB   = 0;
   localparam int FMT_BP_LSB   = 8;
   localparam int FMT_FA_LSB   = 16;
   localparam int FMT_FB_LSB   = 20;
   localparam int ST_CNT_LSB   = 0;
   localparam int ST_EMPTY     = 5;
   localparam int ST_FULL      = 6;
   localparam int ST_BUSY      = 7;
   localparam int ST_LAT_LSB   = 8;
   localparam int ST_PIPE      = 11;

   localparam logic [15:0] CTRL_RST     = 16'h0607;
   localparam logic [23:0] FMT_RST      = 24'h00001a;
   localparam logic [2:0]  LAT_MAX_CODE = 3'h7;
   localparam logic [2:0]  LAT_MAX      = 3'h4;
   localparam logic [5:0]  FULL_BITS    = 6'h1a;

   typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_PORT} mad_op_t;
endpackage

// ### hdl/mad_core.sv
`timescale 1ns/100ps
module mad_core (
   input  wire logic [mad_pkg::OP_W-1:0]   a_i,
   input  wire logic [mad_pkg::OP_W-1:0]   b_i,
   input  wire logic [mad_pkg::C_W-1:0]    c_i,
   input  wire logic                       in_signed_i,
   input  wire logic                       sub_i,
   output logic      [mad_pkg::FULL_W-1:0] full_o
);
   import mad_pkg::*;

   logic [FULL_W-1:0] pa;
   logic [FULL_W-1:0] pb;
   logic [FULL_W-1:0] pc;
   logic [FULL_W-1:0] prod;

   // Extends a w-bit operand to the full result width
   function automatic logic [FULL_W-1:0] ext(
      input logic [C_W-1:0] v,
      input int             w,
      input logic           sgn
   );
      logic [FULL_W-1:0] e;
      e = FULL_W'(v);
      if (sgn && v[w-1])
         e = e | ~((FULL_W'(1) << w) - FULL_W'(1));
      return e;
   endfunction

   assign pa   = ext(C_W'(a_i), OP_W, in_signed_i);
   assign pb   = ext(C_W'(b_i), OP_W, in_signed_i);
   assign pc   = ext(c_i, C_W, in_signed_i);
   // Low bits of the product are exact for both encodings
   assign prod = pa * pb;
   assign full_o = sub_i ? prod - pc : prod + pc;
endmodule // mad_core

// ### hdl/mad_fifo.sv
`timescale 1ns/100ps
module mad_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic                     ref_clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     in_valid_i,
   input  wire logic [WIDTH-1:0]         in_data_i,
   output logic                          in_ready_o,
   output logic                          out_valid_o,
   output logic      [WIDTH-1:0]         out_data_o,
   input  wire logic                     out_ready_i,
   output logic      [$clog2(DEPTH):0]   count_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } mad_fifo_state_t;

   mad_fifo_state_t st_reg;
   mad_fifo_state_t st_next;
   logic            push;
   logic            pop;

   always_comb
   begin
      // Full refuses a push even when a pop frees a slot this cycle
      push    = in_valid_i && (st_reg.cnt != FULL_CNT);
      pop     = out_ready_i && (st_reg.cnt != '0);
      st_next = st_reg;
      if (push)
      begin
         st_next.mem[st_reg.wp] = in_data_i;
         st_next.wp             = st_reg.wp + 1'b1;
      end
      if (pop)
         st_next.rp = st_reg.rp + 1'b1;
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign in_ready_o  = st_reg.cnt != FULL_CNT;
   assign out_valid_o = st_reg.cnt != '0;
   assign out_data_o  = st_reg.mem[st_reg.rp];
   assign count_o     = st_reg.cnt;
endmodule // mad_fifo

// ### hdl/mad_top.sv
`timescale 1ns/100ps
// Function
// - Multiplier outputs product of operands a and b
// - Full precision keeps every result bit exactly
// - User precision narrows bits with quantize, overflow
// - Output encoded signed or unsigned as configured
// - Output binary point counted from bit zero
// - Floating-point mode always yields full precision
// - Result delayed exactly by effective latency
// - Fourth stage filled only at latency four
// - Optional active-high enable input
// - Product combined with c by add or subtract
// - Add, subtract, or per-issue subtract input select
// - Fixed latency zero or max; enable forces max
// - Float latency zero or positive; enable forces positive
module mad_top (
   input  wire logic                       ref_clk_i,
   input  wire logic                       reset_i,
   input  wire logic                       hsel_i,
   input  wire logic [31:0]                haddr_i,
   input  wire logic [1:0]                 htrans_i,
   input  wire logic                       hwrite_i,
   input  wire logic [2:0]                 hsize_i,
   input  wire logic [mad_pkg::DATA_W-1:0] hwdata_i,
   input  wire logic                       hready_i,
   input  wire logic                       enable_i,
   input  wire logic                       sub_i,
   output logic      [mad_pkg::DATA_W-1:0] hrdata_o,
   output logic                            hreadyout_o,
   output logic                            hresp_o
);
   import mad_pkg::*;

   typedef struct packed {
      logic                          hready;
      logic                          hresp;
      logic [DATA_W-1:0]             hrdata;
      logic                          dph_wr;
      logic [7:0]                    dph_addr;
      logic [15:0]                   ctrl;
      logic [23:0]                   fmt;
      logic [OP_W-1:0]               opa;
      logic [OP_W-1:0]               opb;
      logic [C_W-1:0]                opc;
      logic                          pend;
      logic                          pend_sub;
      logic                          en_meta;
      logic                          en_sync;
      logic                          sub_meta;
      logic                          sub_sync;
      logic [STAGES-1:0]             sv;
      logic [STAGES-1:0][FULL_W-1:0] sd;
   } mad_state_t;

   mad_state_t        st_reg;
   mad_state_t        st_next;
   logic [FULL_W-1:0] core_full;
   logic [FULL_W-1:0] tap_d;
   logic [FULL_W-1:0] out_src;
   logic [FULL_W-1:0] exp_uns;
   logic [2:0]        lat;
   logic [1:0]        tap_idx;
   logic [4:0]        ffrac;
   logic [7:0]        a_addr;
   logic              fp;
   logic              user;
   logic              useen;
   logic              osg;
   logic              en_eff;
   logic              tap_v;
   logic              stall;
   logic              adv;
   logic              accept;
   logic              push;
   logic              pop;
   logic              sub_sel;
   logic              wr_now;
   logic              wr_ctrl;
   logic              wr_issue;
   logic [DATA_W-1:0] push_data;
   logic [DATA_W-1:0] status;
   logic [DATA_W-1:0] f_out_data;
   logic              f_in_ready;
   logic              f_out_valid;
   logic [CNT_W-1:0]  f_count;
   mad_op_t           op_mode;

   // Illegal latency codes fall back to the maximum pipeline
   function automatic logic [2:0] eff_lat(
      input logic [2:0] code,
      input logic       is_fp,
      input logic       has_en
   );
      if (code == LAT_MAX_CODE || code > LAT_MAX)
         return LAT_MAX;
      if (!is_fp)
         return (has_en || code != 3'h0) ? LAT_MAX : 3'h0;
      return (has_en && code == 3'h0) ? LAT_MAX : code;
   endfunction

   function automatic logic [STAGES-1:0] stage_mask(input logic [2:0] l);
      return STAGES'((5'h1 << l) - 5'h1);
   endfunction

   function automatic logic [DATA_W-1:0] full_word(
      input logic [FULL_W-1:0] full,
      input logic              sgn
   );
      return {{(DATA_W-FULL_W){sgn && full[FULL_W-1]}}, full};
   endfunction

   function automatic logic [DATA_W-1:0] narrow(
      input logic [FULL_W-1:0] full,
      input logic [4:0]        frac,
      input logic [23:0]       fmt,
      input logic              sgn,
      input logic              rnd,
      input logic              sat
   );
      logic signed [DATA_W-1:0] v;
      logic signed [DATA_W-1:0] hi;
      logic signed [DATA_W-1:0] lo;
      logic [4:0]               obp;
      logic [4:0]               sh;
      logic [5:0]               nb;
      obp = fmt[FMT_BP_LSB +: 5];
      nb  = {1'b0, fmt[FMT_NB_LSB +: 5]};
      if (nb == 6'h0 || nb > FULL_BITS)
         nb = FULL_BITS;
      // Point can only move left; more fraction bits would need a wider word
      sh = (obp < frac) ? frac - obp : 5'h0;
      v  = {{(DATA_W-FULL_W){full[FULL_W-1]}}, full};
      if (rnd && sh != 5'h0)
         v = v + (32'sh1 <<< (sh - 5'h1));
      v  = v >>> sh;
      hi = sgn ? (32'sh1 <<< (nb - 6'h1)) - 32'sh1 : (32'sh1 <<< nb) - 32'sh1;
      lo = sgn ? -(32'sh1 <<< (nb - 6'h1)) : 32'sh0;
      if (sat)
         v = (v > hi) ? hi : ((v < lo) ? lo : v);
      else if (sgn)
         v = (v <<< (6'h20 - nb)) >>> (6'h20 - nb);
      else
         v = v & hi;
      return v;
   endfunction

   assign fp      = st_reg.ctrl[CTRL_FP];
   assign user    = st_reg.ctrl[CTRL_USER];
   assign useen   = st_reg.ctrl[CTRL_USEEN];
   assign osg     = st_reg.ctrl[CTRL_OSGN];
   assign op_mode = mad_op_t'(st_reg.ctrl[CTRL_OP_LSB +: 2]);
   assign lat     = eff_lat(st_reg.ctrl[CTRL_LAT_LSB +: 3], fp, useen);
   assign ffrac   = {1'b0, st_reg.fmt[FMT_FA_LSB +: 4]} + {1'b0, st_reg.fmt[FMT_FB_LSB +: 4]};
   assign en_eff  = !useen || st_reg.en_sync;
   assign tap_idx = 2'(lat - 3'h1);
   assign tap_v   = (lat != 3'h0) && st_reg.sv[tap_idx];
   assign tap_d   = st_reg.sd[tap_idx];
   // A full FIFO stalls the whole pipe while a result waits at the tap, so no result is dropped
   assign stall   = tap_v && !f_in_ready;
   assign adv     = en_eff && !stall;
   assign accept  = st_reg.pend && ((lat == 3'h0) ? f_in_ready : adv);
   assign push    = (lat == 3'h0) ? accept : (tap_v && adv);
   assign out_src = (lat == 3'h0) ? core_full : tap_d;
   assign push_data = (fp || !user) ? full_word(out_src, osg)
                                    : narrow(out_src, ffrac, st_reg.fmt, osg,
                                             st_reg.ctrl[CTRL_RND], st_reg.ctrl[CTRL_SAT]);
   assign wr_now   = st_reg.dph_wr && hready_i;
   assign wr_ctrl  = wr_now && (st_reg.dph_addr == ADDR_CTRL);
   assign wr_issue = wr_now && (st_reg.dph_addr == ADDR_ISSUE);
   assign a_addr   = (haddr_i[31:8] == 24'h0) ? haddr_i[7:0] : ADDR_NONE;
   assign exp_uns  = st_reg.pend_sub
                   ? FULL_W'(st_reg.opa) * FULL_W'(st_reg.opb) - FULL_W'(st_reg.opc)
                   : FULL_W'(st_reg.opa) * FULL_W'(st_reg.opb) + FULL_W'(st_reg.opc);

   always_comb
   begin
      unique case (op_mode)
         OP_ADD:  sub_sel = 1'b0;
         OP_SUB:  sub_sel = 1'b1;
         OP_PORT: sub_sel = st_reg.sub_sync;
         default: sub_sel = 1'b0;
      endcase
   end

   always_comb
   begin
      status = '0;
      status[ST_CNT_LSB +: CNT_W] = f_count;
      status[ST_EMPTY]            = !f_out_valid;
      status[ST_FULL]             = !f_in_ready;
      status[ST_BUSY]             = st_reg.pend;
      status[ST_LAT_LSB +: 3]     = lat;
      status[ST_PIPE]             = st_reg.sv != '0;
   end

   always_comb
   begin
      st_next          = st_reg;
      pop              = 1'b0;
      st_next.en_meta  = enable_i;
      st_next.en_sync  = st_reg.en_meta;
      st_next.sub_meta = sub_i;
      st_next.sub_sync = st_reg.sub_meta;
      st_next.hresp    = 1'b0;
      if (adv)
      begin
         // Stages past the tap stay empty, so the last one fills only at the maximum
         st_next.sv = {st_reg.sv[STAGES-2:0], accept && (lat != 3'h0)} & stage_mask(lat);
         st_next.sd = {st_reg.sd[STAGES-2:0], core_full};
      end
      if (accept)
         st_next.pend = 1'b0;
      if (wr_now)
      begin
         case (st_reg.dph_addr)
            ADDR_CTRL:
            begin
               // New latency would misalign results in flight, so they are dropped
               st_next.ctrl = hwdata_i[15:0];
               st_next.sv   = '0;
            end
            ADDR_FMT:   st_next.fmt = hwdata_i[23:0];
            ADDR_OPA:   st_next.opa = hwdata_i[OP_W-1:0];
            ADDR_OPB:   st_next.opb = hwdata_i[OP_W-1:0];
            ADDR_OPC:   st_next.opc = hwdata_i[C_W-1:0];
            ADDR_ISSUE:
            begin
               st_next.pend     = 1'b1;
               st_next.pend_sub = sub_sel;
            end
            default:    st_next.pend = st_next.pend;
         endcase
      end
      if (hready_i)
      begin
         st_next.dph_wr = 1'b0;
         if (hsel_i && htrans_i[1])
         begin
            st_next.dph_wr   = hwrite_i && (hsize_i == HSIZE_WORD);
            st_next.dph_addr = a_addr;
            if (!hwrite_i)
            begin
               case (a_addr)
                  ADDR_CTRL:   st_next.hrdata = DATA_W'(st_reg.ctrl);
                  ADDR_FMT:    st_next.hrdata = DATA_W'(st_reg.fmt);
                  ADDR_OPA:    st_next.hrdata = DATA_W'(st_reg.opa);
                  ADDR_OPB:    st_next.hrdata = DATA_W'(st_reg.opb);
                  ADDR_OPC:    st_next.hrdata = DATA_W'(st_reg.opc);
                  ADDR_STATUS: st_next.hrdata = status;
                  ADDR_RESULT:
                  begin
                     st_next.hrdata = f_out_valid ? f_out_data : '0;
                     pop            = f_out_valid;
                  end
                  default:     st_next.hrdata = '0;
               endcase
            end
         end
      end
      // Wait states only while an issue waits for the pipe
      st_next.hready = !st_next.pend;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         st_reg        <= '0;
         st_reg.hready <= 1'b1;
         st_reg.ctrl   <= CTRL_RST;
         st_reg.fmt    <= FMT_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   mad_core u_core (
      .a_i         (st_reg.opa),
      .b_i         (st_reg.opb),
      .c_i         (st_reg.opc),
      .in_signed_i (st_reg.ctrl[CTRL_ISGN]),
      .sub_i       (st_reg.pend_sub),
      .full_o      (core_full)
   );

   mad_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (push),
      .in_data_i   (push_data),
      .in_ready_o  (f_in_ready),
      .out_valid_o (f_out_valid),
      .out_data_o  (f_out_data),
      .out_ready_i (pop),
      .count_o     (f_count)
   );

   assign hrdata_o    = st_reg.hrdata;
   assign hreadyout_o = st_reg.hready;
   assign hresp_o     = st_reg.hresp;

   a_core_result: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      accept && !st_reg.ctrl[CTRL_ISGN] |-> core_full == exp_uns)
      else $error("unsigned multiply-add result wrong");

   a_full_prec: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      push && (fp || !user) |-> push_data[FULL_W-1:0] == out_src)
      else $error("full precision result altered");

   a_unsigned_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      push && user && !fp && !osg |-> !push_data[DATA_W-1])
      else $error("unsigned narrowed output has sign bit");

   a_lat_exact: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      accept && lat == 3'h4 ##1 (adv && !wr_ctrl && lat == 3'h4) [*4] |-> push)
      else $error("result not pushed four cycles after issue");

   a_lat_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      accept && lat == 3'h0 |-> push ##1 (f_count == $past(f_count) + 5'h1))
      else $error("zero latency result not pushed with issue");

   a_deep_stage: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      st_reg.sv[STAGES-1] |-> lat == LAT_MAX)
      else $error("last stage filled below maximum latency");

   a_enable_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      useen && !st_reg.en_sync && lat != 3'h0 |-> !push)
      else $error("result pushed while enable low");

   a_sub_port: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      wr_issue && op_mode == OP_PORT |=> st_reg.pend_sub == $past(st_reg.sub_sync))
      else $error("subtract input not sampled at issue");

   a_fixed_lat: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !fp |-> (useen ? lat == LAT_MAX : (lat == 3'h0 || lat == LAT_MAX)))
      else $error("illegal fixed-point latency in use");

   a_float_lat: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      fp && useen |-> lat != 3'h0 && lat <= LAT_MAX)
      else $error("illegal floating-point latency in use");

   a_hold_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !en_eff && !wr_ctrl |=> $stable(st_reg.sv) && $stable(st_reg.sd))
      else $error("pipeline moved while disabled");
endmodule // mad_top

// ### dv/mad_far_model.sv
`timescale 1ns/100ps
module mad_far_model (
   input  wire logic ref_clk_i,
   input  wire logic want_en_i,
   input  wire logic want_sub_i,
   output logic      enable_o,
   output logic      sub_o
);
   // Levels move just after an edge, as real logic would
   always_ff @(posedge ref_clk_i)
   begin
      enable_o <= want_en_i;
      sub_o    <= want_sub_i;
   end
endmodule // mad_far_model

// ### dv/multiply_add_datapath_test.sv
`timescale 1ns/100ps
module multiply_add_datapath_test;
   import mad_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        want_en = 1'b0;
   logic        want_sub = 1'b0;
   logic        en;
   logic        sub;
   logic [31:0] rd;
   int          fail_count = 0;
   int          compares = 0;

   always #50 clk = ~clk;

   mad_far_model u_far (
      .ref_clk_i  (clk),
      .want_en_i  (want_en),
      .want_sub_i (want_sub),
      .enable_o   (en),
      .sub_o      (sub)
   );

   mad_top u_dut (
      .ref_clk_i   (clk),
      .reset_i     (rst),
      .hsel_i      (hsel),
      .haddr_i     (haddr),
      .htrans_i    (htrans),
      .hwrite_i    (hwrite),
      .hsize_i     (hsize),
      .hwdata_i    (hwdata),
      .hready_i    (hready),
      .enable_i    (en),
      .sub_i       (sub),
      .hrdata_o    (hrdata),
      .hreadyout_o (hready),
      .hresp_o     (hresp)
   );

   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   task automatic wait_rdy();
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
   endtask

   // One single word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic calc(input logic [11:0] a, input logic [11:0] b, input logic [23:0] c,
                       input logic [31:0] exp, input string nm);
      bus(1'b1, ADDR_OPA, {20'h0, a});
      bus(1'b1, ADDR_OPB, {20'h0, b});
      bus(1'b1, ADDR_OPC, {8'h0, c});
      bus(1'b1, ADDR_ISSUE, 32'h0);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk(nm, exp, rd);
   endtask

   task automatic t_reset();
      chk("hresp", 32'h0, {31'h0, hresp});
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", {16'h0, CTRL_RST}, rd);
      bus(1'b0, ADDR_FMT, 32'h0);
      chk("fmt reset", {8'h0, FMT_RST}, rd);
      bus(1'b1, ADDR_STATUS, 32'hffff);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status reset", 32'h420, rd);
      bus(1'b1, 8'h20, 32'h1234);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("reset test done");
   endtask

   task automatic t_full();
      bus(1'b1, ADDR_CTRL, 32'h0600);
      calc(12'h003, 12'hffb, 24'h000007, 32'hfffffff8, "mul add");
      calc(12'h800, 12'h800, 24'h7fffff, 32'h00bfffff, "full width");
      bus(1'b1, ADDR_CTRL, 32'h0620);
      calc(12'h003, 12'h004, 24'h000005, 32'h7, "op sub");
      want_sub <= 1'b1;
      repeat (4) @(posedge clk);
      bus(1'b1, ADDR_CTRL, 32'h0640);
      calc(12'h003, 12'h004, 24'h000005, 32'h7, "port sub");
      want_sub <= 1'b0;
      repeat (4) @(posedge clk);
      calc(12'h003, 12'h004, 24'h000005, 32'h11, "port add");
      bus(1'b1, ADDR_CTRL, 32'h0660);
      calc(12'h003, 12'h004, 24'h000005, 32'h11, "op add");
      bus(1'b1, ADDR_CTRL, 32'h0000);
      calc(12'hfff, 12'hfff, 24'h0, 32'h00ffe001, "unsigned");
      bus(1'b1, ADDR_CTRL, 32'h0400);
      calc(12'h003, 12'hffb, 24'h000007, 32'h03fffff8, "zero ext");
      $display("full precision test done");
   endtask

   task automatic t_user();
      bus(1'b1, ADDR_FMT, 32'h440408);
      bus(1'b1, ADDR_CTRL, 32'h0700);
      calc(12'h010, 12'h030, 24'h0, 32'h30, "point 4");
      calc(12'h018, 12'h001, 24'h0, 32'h1, "truncate");
      calc(12'h7ff, 12'h7ff, 24'h0, 32'h0, "wrap");
      bus(1'b1, ADDR_CTRL, 32'h0f00);
      calc(12'h018, 12'h001, 24'h0, 32'h2, "round");
      bus(1'b1, ADDR_CTRL, 32'h1700);
      calc(12'h7ff, 12'h7ff, 24'h0, 32'h7f, "saturate");
      bus(1'b1, ADDR_CTRL, 32'h0500);
      calc(12'hfff, 12'h010, 24'h0, 32'hff, "unsigned wrap");
      bus(1'b1, ADDR_CTRL, 32'h0708);
      calc(12'h010, 12'h030, 24'h0, 32'h300, "float full");
      bus(1'b1, ADDR_FMT, 32'h440810);
      bus(1'b1, ADDR_CTRL, 32'h0700);
      calc(12'h010, 12'h030, 24'h000100, 32'h400, "point 8");
      bus(1'b1, ADDR_FMT, {8'h0, FMT_RST});
      $display("user precision test done");
   endtask

   task automatic t_lat();
      logic [15:0] cc [6] = '{16'h0600, 16'h0602, 16'h0610, 16'h0608, 16'h0609, 16'h0618};
      logic [2:0]  el [6] = '{3'h0, 3'h4, 3'h4, 3'h0, 3'h1, 3'h4};
      foreach (cc[i])
      begin
         bus(1'b1, ADDR_CTRL, {16'h0, cc[i]});
         bus(1'b0, ADDR_STATUS, 32'h0);
         chk("eff latency", {29'h0, el[i]}, {29'h0, rd[10:8]});
      end
      bus(1'b1, ADDR_CTRL, 32'h0604);
      bus(1'b1, ADDR_OPA, 32'h5);
      bus(1'b1, ADDR_OPB, 32'h4);
      bus(1'b1, ADDR_OPC, 32'h0);
      bus(1'b1, ADDR_ISSUE, 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("in flight", 32'hc20, rd);
      repeat (8) @(posedge clk);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("landed", 32'h401, rd);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk("piped value", 32'h14, rd);
      $display("latency test done");
   endtask

   task automatic t_enable();
      bus(1'b1, ADDR_CTRL, 32'h0614);
      bus(1'b1, ADDR_OPA, 32'h2);
      bus(1'b1, ADDR_OPB, 32'h3);
      bus(1'b1, ADDR_OPC, 32'h0);
      bus(1'b1, ADDR_ISSUE, 32'h0);
      repeat (20) @(posedge clk);
      chk("frozen", 32'h0, {31'h0, hready});
      want_en <= 1'b1;
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("accepted", 32'h20, {26'h0, rd[11], rd[4:0]});
      repeat (8) @(posedge clk);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk("enabled value", 32'h6, rd);
      $display("enable test done");
   endtask

   // Fill to full, then drain in order to empty
   task automatic t_fifo();
      bus(1'b1, ADDR_CTRL, 32'h0600);
      bus(1'b1, ADDR_OPB, 32'h1);
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
         bus(1'b1, ADDR_OPA, i);
         bus(1'b1, ADDR_ISSUE, 32'h0);
      end
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("fifo full", 32'h50, rd);
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
         bus(1'b0, ADDR_RESULT, 32'h0);
         chk("fifo order", i, rd);
      end
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("fifo empty", 32'h20, rd);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk("empty read", 32'h0, rd);
      $display("fifo test done");
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_full();
      t_user();
      t_lat();
      t_enable();
      t_fifo();
      complete_run();
   end
endmodule // multiply_add_datapath_test
